// ===== rtl/tvsp_ctrl_port.sv
// two-wire slave control port with subaddressed bank access
`timescale 1ns/1ps
module tvsp_ctrl_port
   import tvsp_pkg::*;
#(
   parameter int ERR_WAIT = ERR_WAIT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // serial bus pins and address-select strap
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe,
   input wire logic [1:0] addr_sel,
   // processing core
   input wire logic core_ready,
   input wire logic core_error,
   input wire logic [15:0] rd_data,
   output logic wr_req,
   output tvsp_wr_t wr_bus,
   output logic rd_req,
   output tvsp_rd_t rd_bus,
   output logic soft_reset
);
   localparam int WW = $clog2(ERR_WAIT + 1);

   typedef enum {ST_IDLE, ST_RX, ST_STRETCH, ST_ACK, ST_TX, ST_MACK, ST_MNEXT} tvsp_state_t;

   function automatic tvsp_bank_t sub_bank(input logic [7:0] s);
      return s[1] ? BANK_AUDIO : BANK_DEMOD;
   endfunction

   function automatic logic sub_is(input logic [7:0] s, input logic [7:0] a, input logic [7:0] b);
      return (s == a) || (s == b);
   endfunction

   logic [1:0] scl_sy_r, sda_sy_r, sel_sy_r, sel_m_r;
   logic scl_d_r, sda_d_r;
   logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
   logic [7:0] own_w;
   tvsp_state_t st_r;
   logic [2:0] bit_cnt_r, idx_r;
   logic [7:0] sh_r, sub_r, word_hi_r;
   logic [15:0] addr_r, rd_data_r;
   logic [WW-1:0] wait_cnt_r;
   logic got8_r, addr_ph_r, rw_r, hi_r, rx_done_r, ctrl_wr_r;
   logic scl_oe_r, sda_oe_r, rd_req_r, wr_req_r, soft_reset_r;
   tvsp_wr_t wr_bus_r;
   tvsp_rd_t rd_bus_r;
   logic [7:0] tx_byte;

   // pins are asynchronous to clk; the second stage feeds all logic
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_sy_r <= 2'h3;
         sda_sy_r <= 2'h3;
         sel_sy_r <= 2'h0;
         sel_m_r <= 2'h0;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_sy_r <= {scl_sy_r[0], serial_clock_pin_in};
         sda_sy_r <= {sda_sy_r[0], serial_data_pin_in};
         sel_m_r <= addr_sel;
         sel_sy_r <= sel_m_r;
         scl_d_r <= scl_sy_r[1];
         sda_d_r <= sda_sy_r[1];
      end
   end

   assign scl_s = scl_sy_r[1];
   assign sda_s = sda_sy_r[1];
   assign scl_rise = scl_s && !scl_d_r;
   assign scl_fall = !scl_s && scl_d_r;
   assign start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;

   // per-bit sync of a two-bit strap is safe only because the pin is static
   logic [1:0] sel_code_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sel_code_r <= SEL_LOW;
      end else begin
         sel_code_r <= sel_sy_r;
      end
   end

   always_comb begin
      unique case (sel_code_r)
         SEL_LOW: own_w = DEV_WR_LOW;
         SEL_HIGH: own_w = DEV_WR_HIGH;
         default: own_w = DEV_WR_OPEN;
      endcase
   end

   assign tx_byte = hi_r ? rd_data_r[15:8] : rd_data_r[7:0];

   // bus engine: data line only changes while the clock is low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= ST_IDLE;
         bit_cnt_r <= 3'h0;
         sh_r <= 8'h00;
         got8_r <= 1'b0;
         addr_ph_r <= 1'b0;
         rw_r <= 1'b0;
         hi_r <= 1'b1;
         wait_cnt_r <= '0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         rd_req_r <= 1'b0;
         rx_done_r <= 1'b0;
         rd_data_r <= 16'h0000;
      end else begin
         rd_req_r <= 1'b0;
         rx_done_r <= 1'b0;
         if (stop_det) begin
            st_r <= ST_IDLE;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
         end else if (start_det) begin
            st_r <= ST_RX;
            bit_cnt_r <= 3'h0;
            got8_r <= 1'b0;
            addr_ph_r <= 1'b1;
            sda_oe_r <= 1'b0;
         end else begin
            unique case (st_r)
               ST_IDLE: ;
               ST_RX: begin
                  if (scl_rise) begin
                     sh_r <= {sh_r[6:0], sda_s};
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     got8_r <= (bit_cnt_r == 3'h7);
                  end else if (scl_fall && got8_r) begin
                     got8_r <= 1'b0;
                     if (!addr_ph_r) begin
                        sda_oe_r <= 1'b1;
                        rx_done_r <= 1'b1;
                        st_r <= ST_ACK;
                     end else if (sh_r[7:1] == own_w[7:1]) begin
                        st_r <= ST_STRETCH;
                        scl_oe_r <= 1'b1;
                        wait_cnt_r <= '0;
                        rw_r <= sh_r[0];
                        rd_req_r <= sh_r[0];
                     end else begin
                        st_r <= ST_IDLE;
                     end
                  end
               end
               ST_STRETCH: begin
                  if (wait_cnt_r != WW'(ERR_WAIT - 1)) begin
                     wait_cnt_r <= wait_cnt_r + 1'b1;
                  end
                  if (core_error) begin
                     // nak by leaving data high, then release the clock
                     if (wait_cnt_r == WW'(ERR_WAIT - 1)) begin
                        scl_oe_r <= 1'b0;
                        st_r <= ST_IDLE;
                     end
                  end else if (core_ready) begin
                     sda_oe_r <= 1'b1;
                     scl_oe_r <= 1'b0;
                     rd_data_r <= rd_data;
                     addr_ph_r <= 1'b0;
                     hi_r <= 1'b1;
                     st_r <= ST_ACK;
                  end
               end
               ST_ACK, ST_MNEXT: begin
                  if (scl_fall) begin
                     bit_cnt_r <= 3'h0;
                     if (rw_r) begin
                        sh_r <= tx_byte;
                        sda_oe_r <= !tx_byte[7];
                        st_r <= ST_TX;
                     end else begin
                        sda_oe_r <= 1'b0;
                        st_r <= ST_RX;
                     end
                  end
               end
               ST_TX: begin
                  if (scl_fall) begin
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     if (bit_cnt_r == 3'h7) begin
                        sda_oe_r <= 1'b0;
                        st_r <= ST_MACK;
                     end else begin
                        sh_r <= {sh_r[6:0], 1'b0};
                        sda_oe_r <= !sh_r[6];
                     end
                  end
               end
               ST_MACK: begin
                  if (scl_rise) begin
                     // a nak, or an ack past the low byte, ends the read
                     if (!sda_s && hi_r) begin
                        hi_r <= 1'b0;
                        st_r <= ST_MNEXT;
                     end else begin
                        st_r <= ST_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // telegram decode; payloads are 16-bit words, high byte first; bank writes send an address word then a data word
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idx_r <= 3'h0;
         sub_r <= SUB_CTRL;
         word_hi_r <= 8'h00;
         addr_r <= 16'h0000;
         wr_req_r <= 1'b0;
         wr_bus_r <= '0;
         rd_bus_r <= '0;
         ctrl_wr_r <= 1'b0;
         soft_reset_r <= SOFT_RESET_INIT;
      end else begin
         wr_req_r <= 1'b0;
         ctrl_wr_r <= 1'b0;
         if (start_det) begin
            idx_r <= 3'h0;
         end else if (rx_done_r) begin
            if (idx_r != 3'h7) begin
               idx_r <= idx_r + 3'h1;
            end
            word_hi_r <= sh_r;
            if (idx_r == 3'h0) begin
               sub_r <= sh_r;
            end else if (idx_r == IDX_WORD_LOW) begin
               if (sub_r == SUB_CTRL) begin
                  soft_reset_r <= word_hi_r[CTRL_RESET_BIT - 8];
                  ctrl_wr_r <= 1'b1;
               end else if (sub_is(sub_r, SUB_DEMOD_BANK_READ_PORT, SUB_AUDIO_BANK_READ_PORT)) begin
                  rd_bus_r <= '{bank: sub_bank(sub_r), addr: {word_hi_r, sh_r}};
               end else begin
                  addr_r <= {word_hi_r, sh_r};
               end
            end else if (idx_r == IDX_DATA_LOW &&
                         sub_is(sub_r, SUB_DEMOD_BANK_WRITE_PORT, SUB_AUDIO_BANK_WRITE_PORT)) begin
               wr_bus_r <= '{bank: sub_bank(sub_r), addr: addr_r, data: {word_hi_r, sh_r}};
               wr_req_r <= 1'b1;
            end
         end
      end
   end

   // open-drain pins only ever pull low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         serial_clock_pin_out <= 1'b0;
         serial_data_pin_out <= 1'b0;
      end else begin
         serial_clock_pin_out <= 1'b0;
         serial_data_pin_out <= 1'b0;
      end
   end

   assign serial_clock_pin_oe = scl_oe_r;
   assign serial_data_pin_oe = sda_oe_r;
   assign wr_req = wr_req_r;
   assign wr_bus = wr_bus_r;
   assign rd_req = rd_req_r;
   assign rd_bus = rd_bus_r;
   assign soft_reset = soft_reset_r;

   addr_match_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(st_r == ST_STRETCH) |-> sh_r[7:1] == own_w[7:1])
      else $error("stretch entered on foreign address");
   rd_addr_a: assert property (@(posedge clk) disable iff (!rstn)
      rd_req_r |-> sh_r == (own_w | 8'h01) && st_r == ST_STRETCH)
      else $error("read request without own read address");
   byte_ack_a: assert property (@(posedge clk) disable iff (!rstn)
      $rose(rx_done_r) |-> sda_oe_r && st_r == ST_ACK)
      else $error("received byte not acknowledged");
   bank_write_a: assert property (@(posedge clk) disable iff (!rstn)
      wr_req_r |-> sub_is(sub_r, SUB_DEMOD_BANK_WRITE_PORT, SUB_AUDIO_BANK_WRITE_PORT)
         && wr_bus_r.bank == sub_bank(sub_r))
      else $error("bank write from wrong subaddress");
   soft_reset_a: assert property (@(posedge clk) disable iff (!rstn)
      $changed(soft_reset_r) |-> ctrl_wr_r && sub_r == SUB_CTRL)
      else $error("soft reset changed outside control write");
   clock_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      st_r == ST_STRETCH |-> scl_oe_r && !sda_oe_r)
      else $error("clock not held during wait");
   err_hold_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == ST_STRETCH && core_error && wait_cnt_r != WW'(ERR_WAIT - 1)
         && !start_det && !stop_det) |=> st_r == ST_STRETCH)
      else $error("error wait ended early");
   err_nak_a: assert property (@(posedge clk) disable iff (!rstn)
      (st_r == ST_STRETCH && core_error && wait_cnt_r == WW'(ERR_WAIT - 1))
         |=> st_r == ST_IDLE && !scl_oe_r && !sda_oe_r [*2])
      else $error("error exit did not nak and release");
   idle_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
      st_r == ST_IDLE |-> !scl_oe_r && !sda_oe_r)
      else $error("idle port drives a bus line");
   msb_first_a: assert property (@(posedge clk) disable iff (!rstn)
      st_r == ST_TX |-> sda_oe_r == !sh_r[7])
      else $error("transmit bit not msb of shifter");

   wr_seen_c: cover property (@(posedge clk) disable iff (!rstn) wr_req_r);
   rd_seen_c: cover property (@(posedge clk) disable iff (!rstn)
      $fell(hi_r) ##[1:1000] st_r == ST_IDLE);
   err_seen_c: cover property (@(posedge clk) disable iff (!rstn)
      st_r == ST_STRETCH && core_error ##1 st_r == ST_IDLE);
   reset_seen_c: cover property (@(posedge clk) disable iff (!rstn) $rose(soft_reset_r));
endmodule // tvsp_ctrl_port

// ===== rtl/tvsp_pkg.sv
// constants and types for the two-wire subaddress control port
package tvsp_pkg;
   // device write addresses per address-select strap; read address is write + 1
   localparam logic [7:0] DEV_WR_LOW = 8'h80;
   localparam logic [7:0] DEV_WR_HIGH = 8'h84;
   localparam logic [7:0] DEV_WR_OPEN = 8'h88;
   // address-select pin sense codes
   localparam logic [1:0] SEL_LOW = 2'h0;
   localparam logic [1:0] SEL_HIGH = 2'h1;
   // subaddresses
   localparam logic [7:0] SUB_CTRL = 8'h00;
   localparam logic [7:0] SUB_TEST = 8'h01;
   localparam logic [7:0] SUB_DEMOD_BANK_WRITE_PORT = 8'h10;
   localparam logic [7:0] SUB_DEMOD_BANK_READ_PORT = 8'h11;
   localparam logic [7:0] SUB_AUDIO_BANK_WRITE_PORT = 8'h12;
   localparam logic [7:0] SUB_AUDIO_BANK_READ_PORT = 8'h13;
   // software_reset_word
   localparam int CTRL_RESET_BIT = 15;
   localparam logic SOFT_RESET_INIT = 1'b0;
   // byte positions after the subaddress
   localparam logic [2:0] IDX_WORD_LOW = 3'h2;
   localparam logic [2:0] IDX_DATA_LOW = 3'h4;
   // timing
   localparam int CLK_PERIOD_NS = 100;
   localparam int ERR_WAIT_NS = 1800000;
   localparam int ERR_WAIT_CYC = ERR_WAIT_NS / CLK_PERIOD_NS;
   localparam int NORMAL_WAIT_NS = 1000000;
   localparam int NORMAL_WAIT_CYC = NORMAL_WAIT_NS / CLK_PERIOD_NS;

   typedef enum logic {BANK_DEMOD, BANK_AUDIO} tvsp_bank_t;
   typedef struct packed {
      tvsp_bank_t bank;
      logic [15:0] addr;
      logic [15:0] data;
   } tvsp_wr_t;
   typedef struct packed {
      tvsp_bank_t bank;
      logic [15:0] addr;
   } tvsp_rd_t;
endpackage

// ===== bench/tvsp_host_model.sv
// host controller model: bus master driving the two-wire control port
`timescale 1ns/1ps
module tvsp_host_model (
   // clock
   input wire logic clk,
   // wire levels
   input wire logic scl,
   input wire logic sda,
   // open-drain pulls, high pulls the line low
   output logic scl_low = 1'b0,
   output logic sda_low = 1'b0
);
   logic stuck = 1'b0;

   // release the clock and wait out a stretch; bounded so a held clock cannot hang
   task automatic rise(output int w);
      scl_low <= 1'b0;
      w = 0;
      @(posedge clk);
      while (!scl && w < 5000) begin
         @(posedge clk);
         w++;
      end
      if (!scl) stuck = 1'b1;
   endtask

   // one bit: 4 clk low, 5 clk high, 900 ns; data moves 2 clk after the fall
   task automatic xfer(input logic b, output logic r, output int w);
      repeat (2) @(posedge clk);
      sda_low <= !b;
      repeat (2) @(posedge clk);
      rise(w);
      repeat (3) @(posedge clk);
      r = sda;
      @(posedge clk);
      scl_low <= 1'b1;
   endtask

   // also serves as repeated start; waits for an ack to be dropped first
   task automatic start();
      int w;
      repeat (4) @(posedge clk);
      sda_low <= 1'b0;
      repeat (2) @(posedge clk);
      rise(w);
      repeat (4) @(posedge clk);
      sda_low <= 1'b1;
      repeat (4) @(posedge clk);
      scl_low <= 1'b1;
   endtask

   task automatic stop();
      int w;
      repeat (2) @(posedge clk);
      sda_low <= 1'b1;
      repeat (2) @(posedge clk);
      rise(w);
      repeat (4) @(posedge clk);
      sda_low <= 1'b0;
      repeat (8) @(posedge clk);
   endtask

   task automatic put_byte(input logic [7:0] b, output logic ack, output int w);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(b[i], r, w);
      xfer(1'b1, r, w);
      ack = !r;
   endtask

   // last high leaves the data line high to end the read
   task automatic get_byte(input logic last, output logic [7:0] d);
      logic r;
      int w;
      for (int i = 7; i >= 0; i--) xfer(1'b1, d[i], w);
      xfer(last, r, w);
   endtask
endmodule // tvsp_host_model

// ===== bench/tvsp_ctrl_port_tb.sv
// self-checking bench for the two-wire subaddress control port
`timescale 1ns/1ps
module tvsp_ctrl_port_tb import tvsp_pkg::*; ;
   localparam int ERR_W = 20;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] addr_sel = SEL_LOW;
   logic core_ready = 1'b0;
   logic core_error = 1'b0;
   logic [15:0] rd_data = 16'h0000;
   logic wr_req, rd_req, soft_reset, scl_oe, scl_out, sda_oe, sda_out;
   logic scl_low, sda_low, scl, sda;
   tvsp_wr_t wr_bus, last_wr;
   tvsp_rd_t rd_bus;
   int core_dly = 2, dly = 0, wr_cnt = 0, error_cnt = 0, total_checks = 0;
   logic [7:0] dev_w;

   assign scl = (scl_oe ? scl_out : 1'b1) & !scl_low;
   assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;

   initial begin
      forever #50 clk = ~clk;
   end

   tvsp_ctrl_port #(.ERR_WAIT(ERR_W)) u_dut (
      .clk(clk), .rstn(rstn), .serial_clock_pin_in(scl), .serial_clock_pin_out(scl_out),
      .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda), .serial_data_pin_out(sda_out),
      .serial_data_pin_oe(sda_oe), .addr_sel(addr_sel), .core_ready(core_ready),
      .core_error(core_error), .rd_data(rd_data), .wr_req(wr_req), .wr_bus(wr_bus),
      .rd_req(rd_req), .rd_bus(rd_bus), .soft_reset(soft_reset));
   tvsp_host_model u_host (.clk(clk), .scl(scl), .sda(sda), .scl_low(scl_low),
      .sda_low(sda_low));

   // core stand-in: ready core_dly cycles into a stretch, read word derived from address
   always @(posedge clk) begin
      if (!scl_oe) begin
         core_ready <= 1'b0;
         dly <= 0;
      end else if (dly >= core_dly) core_ready <= 1'b1;
      else dly <= dly + 1;
      if (rd_req === 1'b1) rd_data <= rd_bus.addr ^ 16'h5a5a ^ {15'h0000, rd_bus.bank};
      if (wr_req === 1'b1) begin
         last_wr <= wr_bus;
         wr_cnt <= wr_cnt + 1;
      end
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check_bit(input logic got, input logic exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask

   task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [7:0] dev_of(input int s);
      return (s == 0) ? DEV_WR_LOW : (s == 1) ? DEV_WR_HIGH : DEV_WR_OPEN;
   endfunction

   task automatic put(input logic [7:0] b);
      logic k;
      int v;
      u_host.put_byte(b, k, v);
      check_bit(k, 1'b1, "byte ack");
   endtask

   task automatic open_dev(input logic [7:0] dev, input logic exp, output logic k, output int w);
      u_host.start();
      u_host.put_byte(dev, k, w);
      check_bit(k, exp, "address ack");
   endtask

   // a hung clock ends the run here
   task automatic close();
      u_host.stop();
      check_bit(u_host.stuck, 1'b0, "clock released");
      if (u_host.stuck) give_verdict();
   endtask

   // aw low drops the address word, as control and test writes need
   task automatic send(input logic [7:0] dev, input logic [7:0] sub, input logic aw,
         input logic [15:0] a, input logic [15:0] d, input logic exp, output int w);
      logic k;
      open_dev(dev, exp, k, w);
      if (k) begin
         put(sub);
         if (aw) begin
            put(a[15:8]);
            put(a[7:0]);
         end
         put(d[15:8]);
         put(d[7:0]);
      end
      close();
   endtask

   task automatic fetch(input logic [7:0] dev, input logic [7:0] sub, input logic [15:0] a,
         output logic [15:0] d);
      logic k;
      int w;
      open_dev(dev, 1'b1, k, w);
      put(sub);
      put(a[15:8]);
      put(a[7:0]);
      open_dev(dev | 8'h01, 1'b1, k, w);
      u_host.get_byte(1'b0, d[15:8]);
      u_host.get_byte(1'b1, d[7:0]);
      close();
   endtask

   initial begin
      int w, n;
      logic [15:0] d;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      for (int s = 0; s < 3; s++) begin
         addr_sel <= 2'(s);
         repeat (4) @(posedge clk);
         dev_w = dev_of(s);
         n = wr_cnt;
         send(dev_of((s + 1) % 3), SUB_DEMOD_BANK_WRITE_PORT, 1'b1, 16'h00bb, 16'h0001, 1'b0, w);
         check_word(16'(w), 16'h0000, "foreign stretch");
         send(dev_w, SUB_DEMOD_BANK_WRITE_PORT, 1'b1, 16'h00bb, 16'h0a5c, 1'b1, w);
         check_bit(last_wr.bank, BANK_DEMOD, "demod bank");
         check_word(last_wr.addr, 16'h00bb, "demod addr");
         check_word(last_wr.data, 16'h0a5c, "demod data");
         send(dev_w, SUB_AUDIO_BANK_WRITE_PORT, 1'b1, 16'h0008, 16'h0120, 1'b1, w);
         check_bit(last_wr.bank, BANK_AUDIO, "audio bank");
         check_word(last_wr.addr, 16'h0008, "audio addr");
         check_word(last_wr.data, 16'h0120, "audio data");
         check_word(16'(wr_cnt - n), 16'h0002, "write count");
         fetch(dev_w, SUB_DEMOD_BANK_READ_PORT, 16'h0023 + 16'(s), d);
         check_word(d, (16'h0023 + 16'(s)) ^ 16'h5a5a, "demod read");
         fetch(dev_w, SUB_AUDIO_BANK_READ_PORT, 16'h8001, d);
         check_word(d, 16'h8001 ^ 16'h5a5b, "audio read");
         $display("test address select %0d done", s);
      end
      n = wr_cnt;
      send(dev_w, SUB_CTRL, 1'b0, 16'h0000, 16'h8000, 1'b1, w);
      check_bit(soft_reset, 1'b1, "soft reset set");
      send(dev_w, SUB_TEST, 1'b0, 16'h0000, 16'h0000, 1'b1, w);
      check_bit(soft_reset, 1'b1, "test write leaves reset");
      send(dev_w, SUB_CTRL, 1'b0, 16'h0000, 16'h7fff, 1'b1, w);
      check_bit(soft_reset, 1'b0, "soft reset cleared");
      check_word(16'(wr_cnt - n), 16'h0000, "control makes no bank write");
      $display("test control word done");
      core_dly <= 60;
      send(dev_w, SUB_AUDIO_BANK_WRITE_PORT, 1'b1, 16'h0001, 16'h0002, 1'b1, w);
      check_bit(w >= 50 && w <= 70, 1'b1, "stretch follows core");
      $display("test stretch done");
      core_dly <= 2;
      core_error <= 1'b1;
      n = wr_cnt;
      send(dev_w, SUB_DEMOD_BANK_WRITE_PORT, 1'b1, 16'h0021, 16'h0001, 1'b0, w);
      check_bit(w >= 10 && w <= ERR_W, 1'b1, "error wait length");
      check_word(16'(wr_cnt - n), 16'h0000, "error write dropped");
      core_error <= 1'b0;
      send(dev_w, SUB_CTRL, 1'b0, 16'h0000, 16'h8000, 1'b1, w);
      check_bit(soft_reset, 1'b1, "recovery reset");
      send(dev_w, SUB_CTRL, 1'b0, 16'h0000, 16'h0000, 1'b1, w);
      check_bit(soft_reset, 1'b0, "recovery release");
      $display("test error recovery done");
      give_verdict();
   end
endmodule // tvsp_ctrl_port_tb
